// ==== logic/hv_cmd_pkg.sv ====
// Package for the high-voltage step / lock command decoder.
// Assumes a single 200 MHz system clock domain.
package hv_cmd_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned NV_WRITE_TIME_NS = 5000;
    localparam int unsigned NV_WRITE_CYCLES =
        (NV_WRITE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CMD_BITS = 8;
    localparam int unsigned WIPER_W  = 9;
    // Register addresses
    localparam logic [3:0] ADDR_WIPER_0 = 4'h0;
    localparam logic [3:0] ADDR_WIPER_1 = 4'h1;
    localparam logic [3:0] ADDR_LOCK_0  = 4'h2;
    localparam logic [3:0] ADDR_LOCK_1  = 4'h3;
    localparam logic [3:0] ADDR_TCON_0  = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h5;
    localparam logic [3:0] ADDR_WIPER_2 = 4'h6;
    localparam logic [3:0] ADDR_WIPER_3 = 4'h7;
    localparam logic [3:0] ADDR_LOCK_2  = 4'h8;
    localparam logic [3:0] ADDR_LOCK_3  = 4'h9;
    localparam logic [3:0] ADDR_TCON_1  = 4'hA;
    localparam logic [3:0] ADDR_PROTECT = 4'hF;
    // Command codes in bits 3:2 of the byte
    localparam logic [1:0] OP_INCR = 2'h1;
    localparam logic [1:0] OP_DECR = 2'h2;
    // Wiper limits
    localparam logic [8:0] WIPER_ZERO = 9'h000;
    localparam logic [8:0] WIPER_FULL = 9'h100;
    localparam logic [8:0] WIPER_RESET = 9'h080;
    // Status field positions
    localparam int unsigned ST_WRITE_BIT = 4;
    localparam int unsigned ST_WP_BIT    = 0;
    localparam int unsigned ST_LOCK_LSB  = 5;
    typedef enum logic [1:0] {
        NV_IDLE    = 2'b01,
        NV_WRITING = 2'b10
    } nv_state_t;
endpackage : hv_cmd_pkg

// ==== logic/hv_lock_protect_command_decoder.sv ====
// Decoder for high-voltage step and lock/protect commands on the serial link.
// Assumes link pins arrive asynchronous; link clock is sampled at 200 MHz.
`timescale 1ns/1ps
`default_nettype none
module hv_lock_protect_command_decoder
    import hv_cmd_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = NV_WRITE_CYCLES
)(
    // Clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_arst_n,
    // Serial link pins
    input  wire logic                  i_select_n,
    input  wire logic                  i_select_hv,
    input  wire logic                  i_sclk,
    input  wire logic                  i_serial_input_pin,
    output logic                       o_serial_output_pin,
    output logic                       o_serial_output_oe_n,
    // Register views
    output logic [WIPER_W-1:0]         o_wiper_0,
    output logic [WIPER_W-1:0]         o_wiper_1,
    output logic [WIPER_W-1:0]         o_wiper_2,
    output logic [WIPER_W-1:0]         o_wiper_3,
    output logic [WIPER_W-1:0]         o_device_status
);
    localparam int unsigned WC_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [3:0]  SYNC_IDLE = 4'h8;  // Select high, all else low

    if (WRITE_CYCLES < 1)
    begin : g_bad_cycles
        $error("WRITE_CYCLES must be at least one");
    end

    // Two-flop synchronisers
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic       sclk_prev;
    logic       sel_prev_n;
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sync_a     <= SYNC_IDLE;  // Pin idle levels: no false edge
            sync_b     <= SYNC_IDLE;
            sclk_prev  <= 1'b0;
            sel_prev_n <= 1'b1;
        end
        else
        begin
            sync_a     <= {i_select_n, i_select_hv, i_sclk,
                           i_serial_input_pin};
            sync_b     <= sync_a;
            sclk_prev  <= sync_b[1];
            sel_prev_n <= sync_b[3];
        end
    end

    logic sel_n;
    logic hv;
    logic sclk_rise;
    logic sel_release;
    assign sel_n       = sync_b[3];
    assign hv          = sync_b[2];
    assign sclk_rise   = sync_b[1] & ~sclk_prev;
    assign sel_release = sel_n & ~sel_prev_n;

    // Bit shifter for the command byte
    logic [CMD_BITS-1:0] shift;
    logic [3:0]          bit_cnt;
    logic                byte_done;
    logic                hv_frame;
    logic [CMD_BITS-1:0] next_shift;
    assign next_shift = {shift[CMD_BITS-2:0], sync_b[0]};
    assign byte_done  = sclk_rise & !sel_n &
                        (bit_cnt == 4'(CMD_BITS - 1));
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            shift    <= '0;
            bit_cnt  <= '0;
            hv_frame <= 1'b1;
        end
        else if (sel_n)  // Idle between frames, whatever the write does
        begin
            bit_cnt  <= '0;
            hv_frame <= 1'b1;
        end
        else if (sclk_rise)
        begin
            shift    <= next_shift;
            hv_frame <= hv_frame & hv;  // Whole byte must see high voltage
            bit_cnt  <= byte_done ? 4'h0 : bit_cnt + 4'h1;
        end
    end

    // Decode of the completed byte
    logic [3:0] addr;
    logic [1:0] op;
    logic       is_step;
    logic       is_hv;
    assign addr    = next_shift[7:4];
    assign op      = next_shift[3:2];
    assign is_step = (op == OP_INCR) || (op == OP_DECR);
    assign is_hv   = hv_frame & hv;

    logic nv_busy;
    logic is_volatile;
    logic is_lock_addr;
    always_comb
    begin
        is_volatile  = 1'b0;
        is_lock_addr = 1'b0;
        case (addr)
            ADDR_WIPER_0, ADDR_WIPER_1, ADDR_WIPER_2, ADDR_WIPER_3,
            ADDR_TCON_0, ADDR_STATUS, ADDR_TCON_1:
                is_volatile = 1'b1;
            ADDR_LOCK_0, ADDR_LOCK_1, ADDR_LOCK_2, ADDR_LOCK_3,
            ADDR_PROTECT:
                is_lock_addr = 1'b1;
            default:
                is_volatile = 1'b0;
        endcase
    end

    // Accepted when volatile, or when no write is running
    logic accept;
    assign accept = byte_done & is_step & (is_volatile | !nv_busy);

    // Wipers step on the eighth clock
    logic [WIPER_W-1:0] wiper [4];
    logic [3:0]         wiper_addr [4];
    assign wiper_addr[0] = ADDR_WIPER_0;
    assign wiper_addr[1] = ADDR_WIPER_1;
    assign wiper_addr[2] = ADDR_WIPER_2;
    assign wiper_addr[3] = ADDR_WIPER_3;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_wiper
            always_ff @(posedge i_mclk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    wiper[gi] <= WIPER_RESET;
                else if (accept && addr == wiper_addr[gi])
                begin
                    if (op == OP_INCR && wiper[gi] < WIPER_FULL)
                        wiper[gi] <= wiper[gi] + 9'h001;
                    else if (op == OP_DECR && wiper[gi] != WIPER_ZERO
                             && wiper[gi] <= WIPER_FULL)
                        wiper[gi] <= wiper[gi] - 9'h001;
                end
            end
        end
    endgenerate

    // Command fault, cleared by select release
    logic cmd_fault;
    logic fault_event;
    assign fault_event = byte_done & is_step &
        ((is_volatile & !(addr inside {ADDR_WIPER_0, ADDR_WIPER_1,
            ADDR_WIPER_2, ADDR_WIPER_3}))
         | (!is_volatile & !is_lock_addr & !nv_busy));
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cmd_fault <= 1'b0;
        else if (fault_event)
            cmd_fault <= 1'b1;
        else if (sel_n)
            cmd_fault <= 1'b0;
    end

    // Pending protection change, launched on select release
    logic       pend_valid;
    logic [2:0] pend_idx;
    logic       pend_val;
    logic [2:0] lock_idx;
    always_comb
    begin
        case (addr)
            ADDR_LOCK_0: lock_idx = 3'h0;
            ADDR_LOCK_1: lock_idx = 3'h1;
            ADDR_LOCK_2: lock_idx = 3'h2;
            ADDR_LOCK_3: lock_idx = 3'h3;
            default:     lock_idx = 3'h4;
        endcase
    end
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            pend_valid <= 1'b0;
            pend_idx   <= '0;
            pend_val   <= 1'b0;
        end
        else if (accept && is_lock_addr && is_hv)
        begin
            pend_valid <= 1'b1;
            pend_idx   <= lock_idx;
            pend_val   <= (op == OP_DECR);
        end
        else if (sel_release || (sclk_rise && !sel_n && bit_cnt == 4'h0))
            pend_valid <= 1'b0;  // Released or extra clocks spoil the form
    end

    // Nonvolatile write cycle
    nv_state_t        nv_state;
    logic [WC_W-1:0]  wc_cnt;
    logic [2:0]       wr_idx;
    logic             wr_val;
    logic [4:0]       nv_bits;
    logic             launch;
    assign launch  = sel_release & pend_valid;
    assign nv_busy = (nv_state == NV_WRITING);
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            nv_state <= NV_IDLE;
            wc_cnt   <= '0;
            wr_idx   <= '0;
            wr_val   <= 1'b0;
            nv_bits  <= '0;
        end
        else
        begin
            case (nv_state)
                NV_IDLE:
                    if (launch)
                    begin
                        nv_state <= NV_WRITING;
                        wc_cnt   <= WC_W'(WRITE_CYCLES - 1);
                        wr_idx   <= pend_idx;
                        wr_val   <= pend_val;
                    end
                NV_WRITING:
                    if (wc_cnt == '0)
                    begin
                        nv_bits[wr_idx] <= wr_val;
                        nv_state        <= NV_IDLE;
                    end
                    else
                        wc_cnt <= wc_cnt - WC_W'(1);
                default:
                    nv_state <= NV_IDLE;
            endcase
        end
    end

    // Registered outputs; serial output is open drain
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_serial_output_pin  <= 1'b0;
            o_serial_output_oe_n <= 1'b1;
            o_wiper_0            <= WIPER_RESET;
            o_wiper_1            <= WIPER_RESET;
            o_wiper_2            <= WIPER_RESET;
            o_wiper_3            <= WIPER_RESET;
            o_device_status      <= '0;
        end
        else
        begin
            o_serial_output_pin  <= 1'b0;
            // Pull low on fault; otherwise release to pull-up
            o_serial_output_oe_n <= !((cmd_fault | fault_event) & !sel_n);
            o_wiper_0            <= wiper[0];
            o_wiper_1            <= wiper[1];
            o_wiper_2            <= wiper[2];
            o_wiper_3            <= wiper[3];
            o_device_status      <= {nv_bits[3:0], nv_busy,
                                     3'h0, nv_bits[4]};
        end
    end

    // Busy-run counter, kept only for the write-length check
    logic [WC_W-1:0] busy_run;
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            busy_run <= '0;
        else
            busy_run <= nv_busy ? busy_run + WC_W'(1) : '0;
    end

    // Assertions
    default clocking mclk_cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);
    fault_low_a: assert property (
        cmd_fault && !sel_n |=> !o_serial_output_oe_n)
        else $error("output not held low on fault");
    nv_ignore_a: assert property (
        nv_busy && byte_done && !is_volatile |-> !accept)
        else $error("nonvolatile command taken while busy");
    vol_take_a: assert property (
        byte_done && is_step && is_volatile |-> accept)
        else $error("volatile command refused");
    launch_rel_a: assert property (
        $rose(nv_busy) |-> $past(sel_release))
        else $error("write launched without select release");
    zero_hold_a: assert property (
        accept && addr == ADDR_WIPER_3 && op == OP_DECR
        && wiper[3] == WIPER_ZERO |=> wiper[3] == WIPER_ZERO)
        else $error("wiper went below zero");
    step_up_a: assert property (
        accept && addr == ADDR_WIPER_1 && op == OP_INCR
        && wiper[1] < WIPER_FULL |=> wiper[1] == $past(wiper[1]) + 9'h001)
        else $error("wiper did not step up");
    fault_set_a: assert property (
        byte_done && is_step && addr == ADDR_STATUS |=> cmd_fault)
        else $error("fault not raised");
    busy_len_a: assert property (
        $fell(nv_busy) |-> busy_run == WC_W'(WRITE_CYCLES))
        else $error("write cycle length wrong");
    busy_stat_a: assert property (
        ##1 o_device_status[ST_WRITE_BIT] == $past(nv_busy))
        else $error("status busy bit wrong");
    cv_lock_c: cover property (launch);
    cv_fault_c: cover property (fault_event);
    cv_busy_step_c: cover property (nv_busy && accept);
endmodule : hv_lock_protect_command_decoder
`default_nettype wire

// ==== sim/hv_host_model.sv ====
// Host model: serial master that drives select, high voltage and link clock.
// Assumes the device samples every link pin with its own system clock.
`timescale 1ns/1ps
`default_nettype none
module hv_host_model (
    // System clock
    input  wire logic i_mclk,
    // Link pins toward the device
    output logic      o_select_n,
    output logic      o_select_hv,
    output logic      o_sclk,
    output logic      o_data
);
    // Idle levels; link clock stands low outside frames
    initial
    begin
        o_select_n  = 1'b1;
        o_select_hv = 1'b0;
        o_sclk      = 1'b0;
        o_data      = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : tick

    // High voltage stays on for the whole frame
    task automatic open_frame(input logic hv);
        @(posedge i_mclk);
        o_select_n  <= 1'b0;
        o_select_hv <= hv;
        tick(7);
    endtask : open_frame

    // MSB first; 7 low plus 6 high cycles make a 65 ns link clock
    task automatic send_byte(input logic [7:0] b);
        for (int k = 7; k >= 0; k--)
        begin
            o_data <= b[k];
            tick(7);
            o_sclk <= 1'b1;
            tick(6);
            o_sclk <= 1'b0;
        end
    endtask : send_byte

    // Released data line shows the inverse, never a stale valid bit
    task automatic close_frame();
        tick(7);
        o_select_n  <= 1'b1;
        o_select_hv <= 1'b0;
        o_data      <= ~o_data;
    endtask : close_frame
endmodule : hv_host_model
`default_nettype wire

// ==== sim/test_hv_lock_protect_command_decoder.sv ====
// Testbench: drives command frames through the host model, checks outputs.
// Assumes a shortened write cycle so that a run stays brief.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            fail_count++; \
            $display("[ERR] %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module test_hv_lock_protect_command_decoder;
    import hv_cmd_pkg::*;
    // Long enough that a two-byte frame ends inside the write cycle
    localparam int unsigned WCYC = 400;
    logic               i_mclk;
    logic               i_arst_n;
    logic               sel_n, sel_hv, sclk, serial_input_pin, serial_output_pin, oe_n;
    logic [WIPER_W-1:0] wv [4];
    logic [WIPER_W-1:0] exp_w [4];
    logic [WIPER_W-1:0] st, exp_st;
    logic [3:0]         wad [4] = '{ADDR_WIPER_0, ADDR_WIPER_1,
                                    ADDR_WIPER_2, ADDR_WIPER_3};
    logic [3:0]         lad [5] = '{ADDR_LOCK_0, ADDR_LOCK_1, ADDR_LOCK_2,
                                    ADDR_LOCK_3, ADDR_PROTECT};
    int                 lbit [5] = '{5, 6, 7, 8, ST_WP_BIT};
    logic [3:0]         bad [7] = '{4'h4, 4'h5, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    int                 fail_count = 0;
    int                 samples_checked = 0;

    hv_host_model i_host (.i_mclk(i_mclk), .o_select_n(sel_n),
        .o_select_hv(sel_hv), .o_sclk(sclk), .o_data(serial_input_pin));

    hv_lock_protect_command_decoder #(.WRITE_CYCLES(WCYC)) i_dut (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_select_n(sel_n),
        .i_select_hv(sel_hv), .i_sclk(sclk), .i_serial_input_pin(serial_input_pin),
        .o_serial_output_pin(serial_output_pin), .o_serial_output_oe_n(oe_n),
        .o_wiper_0(wv[0]), .o_wiper_1(wv[1]), .o_wiper_2(wv[2]),
        .o_wiper_3(wv[3]), .o_device_status(st));

    // 200 MHz system clock
    initial
    begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic test_done();
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    // Outputs are read mid-cycle, where they have settled
    task automatic chk_all();
        @(negedge i_mclk);
        for (int i = 0; i < 4; i++)
            `CHK("wiper", exp_w[i], wv[i])
        `CHK("status", exp_st, st)
    endtask : chk_all

    // One single-byte frame, then let the result settle
    task automatic step(input logic [3:0] a, input logic [1:0] op,
                        input logic hv);
        i_host.open_frame(hv);
        i_host.send_byte({a, op, 2'b00});
        i_host.close_frame();
        repeat (8) @(posedge i_mclk);
    endtask : step

    // Hang guard, well above the expected run of about 250 us
    initial
    begin
        #450us;
        fail_count++;
        test_done();
    end

    initial
    begin
        i_arst_n = 1'b0;
        exp_st   = '0;
        for (int i = 0; i < 4; i++)
            exp_w[i] = WIPER_RESET;
        repeat (2) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        chk_all();
        `CHK("oe_n", 1'b1, oe_n)
        // Each wiper steps by one, with and without high voltage
        for (int i = 0; i < 4; i++)
        begin
            step(wad[i], OP_INCR, 1'b0);
            exp_w[i] = exp_w[i] + 9'h001;
            chk_all();
            step(wad[i], OP_DECR, 1'b1);
            exp_w[i] = exp_w[i] - 9'h001;
            chk_all();
        end
        // Back-to-back decrements hold at zero, then climb to full scale
        i_host.open_frame(1'b0);
        repeat (129) i_host.send_byte({ADDR_WIPER_3, OP_DECR, 2'b00});
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("wiper3 floor", WIPER_ZERO, wv[3])
        @(posedge i_mclk);
        repeat (257) i_host.send_byte({ADDR_WIPER_3, OP_INCR, 2'b00});
        i_host.close_frame();
        repeat (8) @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK("wiper3 top", WIPER_FULL, wv[3])
        step(ADDR_WIPER_3, OP_DECR, 1'b0);
        exp_w[3] = 9'h0FF;
        chk_all();
        // Terminal, status and reserved targets raise the fault only
        for (int i = 0; i < 7; i++)
        begin
            i_host.open_frame(1'b1);
            i_host.send_byte({bad[i], (i % 2) ? OP_INCR : OP_DECR, 2'b00});
            repeat (10) @(posedge i_mclk);
            @(negedge i_mclk);
            `CHK("fault oe_n", 1'b0, oe_n)
            `CHK("sdo", 1'b0, serial_output_pin)
            i_host.close_frame();
            repeat (8) @(posedge i_mclk);
            @(negedge i_mclk);
            `CHK("oe_n cleared", 1'b1, oe_n)
            chk_all();
        end
        // Each lock and the protect bit: set by decrement, cleared by incr
        for (int i = 0; i < 5; i++)
        begin
            step(lad[i], OP_DECR, 1'b1);
            @(negedge i_mclk);
            `CHK("busy", 1'b1, st[ST_WRITE_BIT])
            repeat (WCYC + 10) @(posedge i_mclk);
            exp_st[lbit[i]] = 1'b1;
            chk_all();
            step(lad[i], OP_INCR, 1'b1);
            repeat (WCYC + 10) @(posedge i_mclk);
            exp_st[lbit[i]] = 1'b0;
            chk_all();
        end
        // Write waits for select release; new frame runs during the write
        i_host.open_frame(1'b1);
        i_host.send_byte({ADDR_LOCK_0, OP_DECR, 2'b00});
        repeat (20) @(posedge i_mclk);
        chk_all();
        i_host.close_frame();
        i_host.open_frame(1'b1);
        i_host.send_byte({ADDR_WIPER_0, OP_INCR, 2'b00});
        i_host.send_byte({ADDR_LOCK_1, OP_DECR, 2'b00});
        i_host.close_frame();
        repeat (8) @(posedge i_mclk);
        exp_w[0] = exp_w[0] + 9'h001;
        exp_st[ST_WRITE_BIT] = 1'b1;
        chk_all();
        repeat (WCYC) @(posedge i_mclk);
        exp_st[ST_WRITE_BIT] = 1'b0;
        exp_st[5] = 1'b1;
        chk_all();
        test_done();
    end
endmodule : test_hv_lock_protect_command_decoder
`default_nettype wire
